/* File: pkg/rps_pkg.sv */
// Package: register map, field layout and reset values of the pool/scheduler
package rps_pkg;
    localparam int          RPS_CHANNELS      = 4;
    localparam int          RPS_ADDR_W        = 12;
    localparam int          RPS_TBL_WORDS     = 64;
    localparam int          RPS_ENT_PER_WORD  = 4;
    localparam int          RPS_TBL_ENTRIES   = 256;
    // Byte addresses
    localparam logic [11:0] RPS_FIRST_BASE    = 12'h000;
    localparam logic [11:0] RPS_LATER_BASE    = 12'h010;
    localparam logic [11:0] RPS_SCHED_CTRL    = 12'h020;
    localparam logic [11:0] RPS_SCHED_STATUS  = 12'h024;
    localparam logic [11:0] RPS_TBL_BASE      = 12'h100;
    // Pool register fields
    localparam int          RPS_LO_NUM_LSB    = 0;
    localparam int          RPS_LO_MGR_LSB    = 12;
    localparam int          RPS_HI_NUM_LSB    = 16;
    localparam int          RPS_HI_MGR_LSB    = 28;
    localparam logic [31:0] RPS_POOL_MASK     = 32'h3fff3fff;
    localparam logic [31:0] RPS_POOL_RESET    = 32'h00000000;
    // Scheduler control fields
    localparam int          RPS_EN_BIT        = 31;
    localparam int          RPS_LAST_LSB      = 0;
    localparam logic [31:0] RPS_CTRL_MASK     = 32'h800000ff;
    localparam logic [31:0] RPS_CTRL_RESET    = 32'h00000000;
    // Table entry fields within each byte
    localparam int          RPS_ENT_DIR_BIT   = 7;
    localparam int          RPS_ENT_CHAN_LSB  = 0;
    // AXI responses
    localparam logic [1:0]  RPS_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RPS_RESP_DECERR   = 2'h3;
endpackage

/* File: rtl/rps_dma_sched.sv */
// Receive pool selection registers and credit scheduler with AXI4-Lite slave
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rps_dma_sched
    import rps_pkg::*;
#(
    parameter int NCH = RPS_CHANNELS
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // AXI4-Lite slave
    input  wire logic [RPS_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [RPS_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    // Pool lookup from the receive channels
    input  wire logic                  pool_req_valid_i,
    input  wire logic [1:0]            pool_req_chan_i,
    input  wire logic [7:0]            pool_req_buf_cnt_i,
    output logic                       pool_rsp_valid_o,
    output logic [1:0]                 pool_rsp_mgr_o,
    output logic [11:0]                pool_rsp_num_o,
    // Scheduling credits to the packet DMA
    output logic                       credit_valid_o,
    output logic                       credit_dir_o,
    output logic [3:0]                 credit_chan_o,
    input  wire logic                  credit_ready_i
);
    // Address map (byte addresses): first pool words 0x000 + 4n, later pool
    // words 0x010 + 4n, control 0x020, status 0x024 (credit pending in bit
    // 31, current slot in bits 7:0), table words 0x100 + 4w; all else
    // answers DECERR and changes nothing.
    // Register state
    logic [31:0]           first_pools_cfg_reg [NCH];
    logic [31:0]           later_pools_cfg_reg [NCH];
    logic [31:0]           scheduler_control_reg;
    logic [4:0]            sched_tbl_reg [RPS_TBL_ENTRIES];
    logic [7:0]            slot_idx_reg;
    // Bus state
    logic                  awready_reg;
    logic                  wready_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic [RPS_ADDR_W-1:0] awaddr_reg;
    logic [31:0]           wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  arready_reg;
    logic                  rvalid_reg;
    logic [1:0]            rresp_reg;
    logic [31:0]           rdata_reg;
    // Lookup and credit outputs
    logic                  pool_rsp_valid_reg;
    logic [1:0]            pool_rsp_mgr_reg;
    logic [11:0]           pool_rsp_num_reg;
    logic                  credit_valid_reg;
    logic                  credit_dir_reg;
    logic [3:0]            credit_chan_reg;

    // Decoded strobes and selections
    logic                  wr_go;
    logic [NCH-1:0]        first_hit;
    logic [NCH-1:0]        later_hit;
    logic                  ctrl_hit;
    logic                  tbl_hit;
    logic                  sched_en;
    logic [7:0]            last_entry;
    logic [7:0]            slot_idx_next;
    logic [4:0]            fetch_entry;
    logic [31:0]           rd_word;
    logic [31:0]           pool_pair_word;
    logic                  pool_upper;
    logic [1:0]            pool_sel_mgr;
    logic [11:0]           pool_sel_num;

    // Byte-lane merge of a write into a masked register
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res & mask;
    endfunction

    // Address is one of the mapped word locations
    function automatic logic mapped(input logic [RPS_ADDR_W-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'h0) begin
            if (a < RPS_SCHED_STATUS + 12'h004) begin
                ok = 1'b1;
            end
            if (a >= RPS_TBL_BASE &&
                a < RPS_TBL_BASE + 12'(4 * RPS_TBL_WORDS)) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // A write commits once both halves are held and no response is pending
    assign wr_go      = !awready_reg && !wready_reg && !bvalid_reg;
    assign sched_en   = scheduler_control_reg[RPS_EN_BIT];
    assign last_entry = scheduler_control_reg[RPS_LAST_LSB +: 8];
    // Wrap also covers a last entry lowered beneath the current slot
    assign slot_idx_next = (slot_idx_reg >= last_entry) ? 8'h00
                                                        : slot_idx_reg + 8'h01;
    assign fetch_entry   = sched_tbl_reg[slot_idx_reg];

    // Write decode: one strobe per pool and control register, one for the whole table, valid only in the commit cycle
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            first_hit[c] = wr_go && awaddr_reg == RPS_FIRST_BASE + 12'(4 * c);
            later_hit[c] = wr_go && awaddr_reg == RPS_LATER_BASE + 12'(4 * c);
        end
        ctrl_hit = wr_go && awaddr_reg == RPS_SCHED_CTRL;
        tbl_hit  = wr_go && mapped(awaddr_reg) && awaddr_reg >= RPS_TBL_BASE;
    end

    // Write address held from its take until the response is accepted;
    // awready stays low while a response is pending, so one write at a time
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            awready_reg <= 1'b1;
            awaddr_reg  <= '0;
        end else if (awready_reg && s_axi_awvalid_i) begin
            awready_reg <= 1'b0;
            awaddr_reg  <= s_axi_awaddr_i;
        end else if (bvalid_reg && s_axi_bready_i) begin
            awready_reg <= 1'b1;
        end
    end

    // Write data held the same way; address and data may come in any order
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wready_reg <= 1'b1;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end else if (wready_reg && s_axi_wvalid_i) begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
        end else if (bvalid_reg && s_axi_bready_i) begin
            wready_reg <= 1'b1;
        end
    end

    // Response raised the cycle after the commit cycle, dropped when taken
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RPS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(awaddr_reg) ? RPS_RESP_OKAY
                                             : RPS_RESP_DECERR;
        end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Pool registers, one pair per channel
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                first_pools_cfg_reg[c] <= RPS_POOL_RESET;
                later_pools_cfg_reg[c] <= RPS_POOL_RESET;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (first_hit[c]) begin
                    first_pools_cfg_reg[c] <= merge(first_pools_cfg_reg[c],
                        wdata_reg, wstrb_reg, RPS_POOL_MASK);
                end
                if (later_hit[c]) begin
                    later_pools_cfg_reg[c] <= merge(later_pools_cfg_reg[c],
                        wdata_reg, wstrb_reg, RPS_POOL_MASK);
                end
            end
        end
    end

    // Scheduler control
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            scheduler_control_reg <= RPS_CTRL_RESET;
        end else if (ctrl_hit) begin
            scheduler_control_reg <= merge(scheduler_control_reg, wdata_reg,
                                           wstrb_reg, RPS_CTRL_MASK);
        end
    end

    // Table: byte lane k of word w is entry 4*w+k
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int e = 0; e < RPS_TBL_ENTRIES; e++) begin
                sched_tbl_reg[e] <= 5'h00;
            end
        end else if (tbl_hit) begin
            for (int k = 0; k < RPS_ENT_PER_WORD; k++) begin
                if (wstrb_reg[k]) begin
                    sched_tbl_reg[{awaddr_reg[7:2], 2'(k)}] <= {
                        wdata_reg[8*k + RPS_ENT_DIR_BIT],
                        wdata_reg[8*k + RPS_ENT_CHAN_LSB +: 4]
                    };
                end
            end
        end
    end

    // Read decode; pool and table words are write-only and read zero
    always_comb begin
        rd_word = 32'h00000000;
        if (s_axi_araddr_i == RPS_SCHED_CTRL) begin
            rd_word = scheduler_control_reg;
        end
        if (s_axi_araddr_i == RPS_SCHED_STATUS) begin
            rd_word = {credit_valid_reg, 23'h000000, slot_idx_reg};
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RPS_RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end else begin
            if (arready_reg && s_axi_arvalid_i) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= mapped(s_axi_araddr_i) ? RPS_RESP_OKAY
                                                      : RPS_RESP_DECERR;
                rdata_reg   <= rd_word;
            end
            if (rvalid_reg && s_axi_rready_i) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // Pool selection: buffer count 0,1,2 pick a half each, 3 and up share one
    always_comb begin
        pool_pair_word = first_pools_cfg_reg[pool_req_chan_i];
        pool_upper     = pool_req_buf_cnt_i[0];
        if (pool_req_buf_cnt_i >= 8'h02) begin
            pool_pair_word = later_pools_cfg_reg[pool_req_chan_i];
            pool_upper     = (pool_req_buf_cnt_i != 8'h02);
        end
        if (pool_upper) begin
            pool_sel_mgr = pool_pair_word[RPS_HI_MGR_LSB +: 2];
            pool_sel_num = pool_pair_word[RPS_HI_NUM_LSB +: 12];
        end else begin
            pool_sel_mgr = pool_pair_word[RPS_LO_MGR_LSB +: 2];
            pool_sel_num = pool_pair_word[RPS_LO_NUM_LSB +: 12];
        end
    end

    // Lookup answer registered one cycle after each request cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pool_rsp_valid_reg <= 1'b0;
            pool_rsp_mgr_reg   <= 2'h0;
            pool_rsp_num_reg   <= 12'h000;
        end else begin
            pool_rsp_valid_reg <= pool_req_valid_i;
            if (pool_req_valid_i) begin
                pool_rsp_mgr_reg <= pool_sel_mgr;
                pool_rsp_num_reg <= pool_sel_num;
            end
        end
    end

    // Credit scheduler: fetch, present, advance after acceptance
    // A credit stands until taken; clearing the enable withdraws it
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            slot_idx_reg     <= 8'h00;
            credit_valid_reg <= 1'b0;
            credit_dir_reg   <= 1'b0;
            credit_chan_reg  <= 4'h0;
        end else if (!sched_en) begin
            slot_idx_reg     <= 8'h00;
            credit_valid_reg <= 1'b0;
        end else if (credit_valid_reg) begin
            if (credit_ready_i) begin
                credit_valid_reg <= 1'b0;
                slot_idx_reg     <= slot_idx_next;
            end
        end else begin
            credit_valid_reg <= 1'b1;
            credit_dir_reg   <= fetch_entry[4];
            credit_chan_reg  <= fetch_entry[3:0];
        end
    end

    assign s_axi_awready_o  = awready_reg;
    assign s_axi_wready_o   = wready_reg;
    assign s_axi_bvalid_o   = bvalid_reg;
    assign s_axi_bresp_o    = bresp_reg;
    assign s_axi_arready_o  = arready_reg;
    assign s_axi_rvalid_o   = rvalid_reg;
    assign s_axi_rresp_o    = rresp_reg;
    assign s_axi_rdata_o    = rdata_reg;
    assign pool_rsp_valid_o = pool_rsp_valid_reg;
    assign pool_rsp_mgr_o   = pool_rsp_mgr_reg;
    assign pool_rsp_num_o   = pool_rsp_num_reg;
    assign credit_valid_o   = credit_valid_reg;
    assign credit_dir_o     = credit_dir_reg;
    assign credit_chan_o    = credit_chan_reg;
endmodule

/* File: test/rps_dma_sched_chk.sv */
// Checker: port-level assertions for the pool and scheduler block
`timescale 1ns/1ps
module rps_dma_sched_chk
    import rps_pkg::*;
#(
    parameter int NCH = RPS_CHANNELS
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        s_axi_awready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        pool_req_valid_i,
    input wire logic        pool_rsp_valid_o,
    input wire logic [11:0] pool_rsp_num_o,
    input wire logic        credit_valid_o,
    input wire logic        credit_ready_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    AST_POOL_ANS: assert property (pool_req_valid_i |=> pool_rsp_valid_o)
        else $error("pool answer missing");
    AST_POOL_QUIET: assert property (!pool_req_valid_i |=>
        !pool_rsp_valid_o && $stable(pool_rsp_num_o)) else $error("pool idle");
    AST_CRED_GAP: assert property (credit_valid_o && credit_ready_i
        |=> !credit_valid_o) else $error("credit gap missing");
    AST_B_STAND: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b drop");
    AST_AW_BUSY: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("aw ready while b pending");
    AST_R_ANS: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("r late");
    AST_R_STAND: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r drop");
    AST_ERR_ZERO: assert property (s_axi_rvalid_o &&
        s_axi_rresp_o == RPS_RESP_DECERR |-> s_axi_rdata_o == 32'h0)
        else $error("error read data not zero");
endmodule
bind rps_dma_sched rps_dma_sched_chk #(.NCH(NCH)) chk_inst (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (rst_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .pool_req_valid_i(pool_req_valid_i),
    .pool_rsp_valid_o(pool_rsp_valid_o),
    .pool_rsp_num_o  (pool_rsp_num_o),
    .credit_valid_o  (credit_valid_o),
    .credit_ready_i  (credit_ready_i)
);

/* File: test/rps_credit_sink.sv */
// Partner: DMA side that accepts scheduling credits, fast or stalling
`timescale 1ns/1ps
module rps_credit_sink (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       slow_i,
    input  wire logic       valid_i,
    input  wire logic       dir_i,
    input  wire logic [3:0] chan_i,
    output logic            ready_o,
    output logic            acc_o,
    output logic            acc_dir_o,
    output logic [3:0]      acc_chan_o
);
    logic ph_reg;
    always_ff @(posedge clk_sys_i) begin
        ph_reg <= rst_i ? 1'b0 : ~ph_reg;
    end
    assign ready_o = slow_i ? ph_reg : 1'b1;
    always_ff @(posedge clk_sys_i) begin
        acc_o <= !rst_i && valid_i && ready_o;
        if (valid_i && ready_o) begin
            acc_dir_o  <= dir_i;
            acc_chan_o <= chan_i;
        end
    end
endmodule

/* File: test/rps_dma_sched_tb.sv */
// Testbench: register, pool lookup and credit sequence tests
`timescale 1ns/1ps
module rps_dma_sched_tb;
    import rps_pkg::*;
    logic        clk = 1'b0;
    logic        rst, awvalid, wvalid, bready, arvalid, rready, pv, slow;
    logic [11:0] awaddr, araddr, pnum;
    logic [31:0] wdata, rdata, d, e;
    logic        awready, wready, bvalid, arready, rvalid, prv;
    logic        cv, cdir, crdy, acc, adir;
    logic [1:0]  bresp, rresp, r, pch, pmgr;
    logic [3:0]  cch, ach;
    logic [7:0]  pcnt, b;
    logic [31:0] va[4], vb[4];
    logic [31:0] tw[3] = '{32'h8f71e302, 32'h000000f5, 32'h8c8c8c8c};
    int          n_fail = 0, samples_checked = 0, cyc = 0;
    always #4 clk = ~clk;
    rps_dma_sched rps_dma_sched_inst (
        .clk_sys_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pool_req_valid_i(pv), .pool_req_chan_i(pch),
        .pool_req_buf_cnt_i(pcnt), .pool_rsp_valid_o(prv),
        .pool_rsp_mgr_o(pmgr), .pool_rsp_num_o(pnum),
        .credit_valid_o(cv), .credit_dir_o(cdir), .credit_chan_o(cch),
        .credit_ready_i(crdy));
    rps_credit_sink rps_credit_sink_inst (
        .clk_sys_i(clk), .rst_i(rst), .slow_i(slow), .valid_i(cv),
        .dir_i(cdir), .chan_i(cch), .ready_o(crdy), .acc_o(acc),
        .acc_dir_o(adir), .acc_chan_o(ach));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic pool(input logic [1:0] c, input logic [7:0] n);
        @(posedge clk);
        pv <= 1; pch <= c; pcnt <= n;
        @(posedge clk);
        pv <= 0;
        #1 chk(32'(prv), 32'h1);
    endtask
    task automatic cred(input int i);
        b = tw[(i % 5) / 4][8 * ((i % 5) % 4) +: 8];
        do @(posedge clk); while (acc !== 1'b1);
        chk(32'({adir, ach}), 32'({b[7], b[3:0]}));
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, pv, pch, pcnt, slow} = '0;
        rst = 1;
        repeat (16) @(posedge clk);
        rst <= 0;
        rd(RPS_SCHED_CTRL); chk(d, 32'h0);
        pool(2'd3, 8'd5); chk(32'(pnum), 32'h0);
        for (int c = 0; c < 4; c++) begin
            va[c] = 32'hc5a5f3c3 ^ (c * 32'h13572468);
            vb[c] = ~va[c];
            wr(RPS_FIRST_BASE + 12'(4 * c), va[c]); chk(32'(r), 32'h0);
            wr(RPS_LATER_BASE + 12'(4 * c), vb[c]); chk(32'(r), 32'h0);
        end
        rd(RPS_LATER_BASE + 12'h4); chk(d, 32'h0);
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 5; k++) begin
                e = (k < 2) ? va[c] & RPS_POOL_MASK : vb[c] & RPS_POOL_MASK;
                if (k % 2 == 1 || k == 4) e = e >> 16;
                pool(2'(c), (k == 4) ? 8'd200 : 8'(k > 3 ? 3 : k));
                chk(32'({pmgr, pnum}), 32'(e[13:0]));
            end
        wr(12'h200, 32'h1); chk(32'(r), 32'(RPS_RESP_DECERR));
        wr(12'h002, 32'h1); chk(32'(r), 32'(RPS_RESP_DECERR));
        rd(12'h300); chk(32'(r), 32'(RPS_RESP_DECERR));
        for (int w = 0; w < 3; w++) wr(RPS_TBL_BASE + 12'(4 * w), tw[w]);
        wr(RPS_SCHED_CTRL, 32'hffffff04);
        for (int i = 0; i < 12; i++) begin
            slow <= (i >= 6);
            cred(i);
        end
        rd(RPS_SCHED_CTRL); chk(d, 32'h80000004);
        wr(RPS_SCHED_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        repeat (8) @(posedge clk) chk(32'(cv), 32'h0);
        rd(RPS_SCHED_STATUS); chk(d, 32'h0);
        wr(RPS_SCHED_CTRL, 32'h80000000);
        repeat (3) cred(0);
        finish_test;
    end
endmodule
